/* sdc_converter_control.v */
`timescale 1ns/1ps
`default_nettype none
`include "sdc_regs.vh"
module sdc_converter_control #(
  parameter OVR_CYCLES = `SDC_OVR_CYCLES,
  parameter CAL_CYCLES = 1024
) (
  input wire clk,
  input wire resetn,
  input wire [7:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWrite,
  input wire regRead,
  output reg [31:0] regRdata,
  input wire currentModBit,
  input wire voltageModBit,
  input wire currentOverrangeRaw,
  output wire [1:0] inputSelect,
  output wire attenBufferEn,
  output wire gndSwDirect,
  output wire gndSwResistor,
  output wire convIrq
);
  // =====================================================
  // pin synchronisers
  reg [1:0] curSync, volSync, ovrSync;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      curSync <= 2'b00;
      volSync <= 2'b00;
      ovrSync <= 2'b00;
    end else begin
      curSync <= {curSync[0], currentModBit};
      volSync <= {volSync[0], voltageModBit};
      ovrSync <= {ovrSync[0], currentOverrangeRaw};
    end
  end
  // =====================================================
  // registers
  reg [15:0] mode_reg, config_reg, filter_reg, mask_reg;
  reg [15:0] thresh_reg, count_reg;
  reg [15:0] current_result_reg, voltage_result_reg, temperature_result_reg;
  reg [31:0] accum_reg;
  reg [15:0] status_reg;
  reg [15:0] cntProgress_reg;
  reg [1:0] curSettle_reg, volSettle_reg;
  reg [31:0] ovrTimer_reg;
  reg [31:0] calTimer_reg;
  reg calBusy_reg;
  wire wrMode = regWrite && regAddr == `SDC_MODE_OFF;
  wire wrCfg = regWrite && regAddr == `SDC_CONFIG_OFF;
  wire wrFlt = regWrite && regAddr == `SDC_FILTER_OFF;
  wire curEn = mode_reg[`SDC_MD_CUREN];
  wire vtEn = mode_reg[`SDC_MD_VTEN];
  wire coreOff = mode_reg[`SDC_MD_CORE_OFF];
  wire chopOn = mode_reg[`SDC_MD_CHOP];
  wire chopNext = wrMode ? regWdata[`SDC_MD_CHOP] : chopOn;
  wire [1:0] vSel = config_reg[`SDC_CF_VSEL_LO+1:`SDC_CF_VSEL_LO];
  assign inputSelect = vSel;
  assign attenBufferEn = vtEn && vSel == `SDC_SEL_VBAT;
  assign gndSwDirect = config_reg[`SDC_CF_GSW] && !mode_reg[`SDC_MD_GSW_RES];
  assign gndSwResistor = config_reg[`SDC_CF_GSW] && mode_reg[`SDC_MD_GSW_RES];
  // =====================================================
  // rate from filter register
  function [23:0] decimOf;
    input [15:0] flt;
    input lowPwr;
    reg [23:0] base;
    begin
      base = {17'h00000, `SDC_BASE_DECIM} * ({16'h0000, flt[7:0]} + 24'h000001) *
             ({16'h0000, flt[15:8]} + 24'h000001);
      decimOf = lowPwr ? {base[21:0], 2'b00} : base;
    end
  endfunction
  wire [23:0] curDecim = decimOf(filter_reg, mode_reg[`SDC_MD_LOWPWR]);
  wire [23:0] volDecim = decimOf(filter_reg, 1'b0);
  wire [15:0] curRes, volRes;
  wire curClip, volClip, curDone, volDone;
  sdc_sinc3 #(.ACC_W(80)) uCur (
    .clk(clk),
    .resetn(resetn),
    .enable(curEn),
    .modBit(curSync[1]),
    .decim(curDecim),
    .result(curRes),
    .clip(curClip),
    .done(curDone)
  );
  sdc_sinc3 #(.ACC_W(80)) uVol (
    .clk(clk),
    .resetn(resetn),
    .enable(vtEn),
    .modBit(volSync[1]),
    .decim(volDecim),
    .result(volRes),
    .clip(volClip),
    .done(volDone)
  );
  // =====================================================
  // settling and result gating
  wire curSettled = curSettle_reg == 2'h0;
  wire volSettled = volSettle_reg == 2'h0;
  wire curNew = curDone && curSettled;
  wire volNew = volDone && volSettled;
  wire isTemp = vSel != `SDC_SEL_VBAT;
  wire volRdy = status_reg[`SDC_ST_VOLRDY] || status_reg[`SDC_ST_TMPRDY];
  wire curLoad = curNew && (coreOff || !status_reg[`SDC_ST_CURRDY]);
  wire volLoad = volNew && (coreOff || !volRdy);
  wire rdCur = regRead && regAddr == `SDC_CURRENT_OFF;
  wire rdVT = regRead && (regAddr == `SDC_VOLTAGE_OFF || regAddr == `SDC_TEMP_OFF);
  wire clrReady = rdCur || (rdVT && !curEn);
  wire [15:0] absCur = curRes[15] ? (~curRes + 16'h0001) : curRes;
  wire cntMode = config_reg[`SDC_CF_CNT];
  wire cmpHit = config_reg[`SDC_CF_CMP] && curNew &&
                (cntMode ? (cntProgress_reg + 16'h0001 >= count_reg) : (absCur > thresh_reg));
  wire ovrTick = ovrTimer_reg >= OVR_CYCLES - 1;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      curSettle_reg <= `SDC_SETTLE_NOCHOP;
      volSettle_reg <= `SDC_SETTLE_NOCHOP;
    end else begin
      if (wrMode || wrCfg || wrFlt || !curEn)
        curSettle_reg <= chopNext ? `SDC_SETTLE_CHOP - 2'h1 : `SDC_SETTLE_NOCHOP - 2'h1;
      else if (curDone && !curSettled)
        curSettle_reg <= curSettle_reg - 2'h1;
      if ((wrCfg && regWdata[`SDC_CF_VSEL_LO+1:`SDC_CF_VSEL_LO] != vSel) || wrFlt || !vtEn)
        volSettle_reg <= `SDC_SETTLE_NOCHOP - 2'h1;
      else if (volDone && !volSettled)
        volSettle_reg <= volSettle_reg - 2'h1;
    end
  end
  // =====================================================
  // results, accumulator, counter, overrange timer
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      current_result_reg <= 16'h0000;
      voltage_result_reg <= 16'h0000;
      temperature_result_reg <= 16'h0000;
      accum_reg <= 32'h00000000;
      cntProgress_reg <= 16'h0000;
      ovrTimer_reg <= 32'h00000000;
    end else begin
      if (curLoad)
        current_result_reg <= curRes;
      if (volLoad && !isTemp)
        voltage_result_reg <= volRes;
      if (volLoad && isTemp)
        temperature_result_reg <= volRes;
      if (!config_reg[`SDC_CF_ACC])
        accum_reg <= 32'h00000000;
      else if (curNew)
        accum_reg <= accum_reg + {{16{curRes[15]}}, curRes};
      if (wrCfg || !cntMode || cmpHit)
        cntProgress_reg <= 16'h0000;
      else if (curNew)
        cntProgress_reg <= cntProgress_reg + 16'h0001;
      ovrTimer_reg <= ovrTick ? 32'h00000000 : ovrTimer_reg + 32'h00000001;
    end
  end
  // =====================================================
  // status flags, set wins over clear except overrange, where a clear SDC_CF_OVR bit wins
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status_reg <= 16'h0000;
      calBusy_reg <= 1'b0;
      calTimer_reg <= 32'h00000000;
    end else begin
      if (clrReady) begin
        status_reg[`SDC_ST_CURRDY] <= 1'b0;
        status_reg[`SDC_ST_VOLRDY] <= 1'b0;
        status_reg[`SDC_ST_TMPRDY] <= 1'b0;
      end
      if (curNew)
        status_reg[`SDC_ST_CURRDY] <= 1'b1;
      if (volNew && !isTemp)
        status_reg[`SDC_ST_VOLRDY] <= 1'b1;
      if (volNew && isTemp)
        status_reg[`SDC_ST_TMPRDY] <= 1'b1;
      if (!config_reg[`SDC_CF_OVR])
        status_reg[`SDC_ST_OVR] <= 1'b0;
      else if (ovrTick && ovrSync[1])
        status_reg[`SDC_ST_OVR] <= 1'b1;
      if (cmpHit)
        status_reg[`SDC_ST_THR] <= 1'b1;
      else if (!config_reg[`SDC_CF_CMP] || wrCfg)
        status_reg[`SDC_ST_THR] <= 1'b0;
      if (curLoad)
        status_reg[12] <= curClip;
      if (volLoad && !isTemp)
        status_reg[13] <= volClip;
      if (volLoad && isTemp)
        status_reg[14] <= volClip;
      if (wrMode && regWdata[`SDC_MD_CAL]) begin
        calBusy_reg <= 1'b1;
        calTimer_reg <= 32'h00000000;
      end else if (calBusy_reg) begin
        calTimer_reg <= calTimer_reg + 32'h00000001;
        if (calTimer_reg >= CAL_CYCLES - 1)
          calBusy_reg <= 1'b0;
      end
      if (calBusy_reg && calTimer_reg >= CAL_CYCLES - 1)
        status_reg[`SDC_ST_CAL] <= 1'b1;
      else if (wrMode)
        status_reg[`SDC_ST_CAL] <= 1'b0;
    end
  end
  assign convIrq = |(status_reg[7:0] & mask_reg[7:0]);
  // =====================================================
  // register write and read
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_reg <= 16'h0000;
      config_reg <= 16'h0000;
      filter_reg <= `SDC_FILTER_RST;
      mask_reg <= 16'h0000;
      thresh_reg <= 16'hFFFF;
      count_reg <= 16'h0001;
      regRdata <= 32'h00000000;
    end else begin
      if (wrMode)
        mode_reg <= {12'h000, 1'b0, regWdata[2:0]} & 16'hFFFB | (regWdata[15:0] & 16'h0078);
      if (wrCfg)
        config_reg <= regWdata[15:0];
      if (wrFlt)
        filter_reg <= regWdata[15:0];
      if (regWrite && regAddr == `SDC_MASK_OFF)
        mask_reg <= {8'h00, regWdata[7:0]};
      if (regWrite && regAddr == `SDC_THRESH_OFF)
        thresh_reg <= regWdata[15:0];
      if (regWrite && regAddr == `SDC_COUNT_OFF)
        count_reg <= regWdata[15:0];
      regRdata <= 32'h00000000;
      if (regRead) begin
        case (regAddr)
          `SDC_STATUS_OFF: regRdata <= {16'h0000, status_reg};
          `SDC_MASK_OFF: regRdata <= {16'h0000, mask_reg};
          `SDC_MODE_OFF: regRdata <= {16'h0000, mode_reg};
          `SDC_CONFIG_OFF: regRdata <= {16'h0000, config_reg};
          `SDC_FILTER_OFF: regRdata <= {16'h0000, filter_reg};
          `SDC_CURRENT_OFF: regRdata <= {16'h0000, current_result_reg};
          `SDC_VOLTAGE_OFF: regRdata <= {16'h0000, voltage_result_reg};
          `SDC_TEMP_OFF: regRdata <= {16'h0000, temperature_result_reg};
          `SDC_THRESH_OFF: regRdata <= {16'h0000, thresh_reg};
          `SDC_COUNT_OFF: regRdata <= {16'h0000, count_reg};
          `SDC_ACCUM_OFF: regRdata <= accum_reg;
          default: regRdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // sdc_converter_control
`default_nettype wire

/* sdc_regs.vh */
`ifndef SDC_REGS_VH
`define SDC_REGS_VH
// =====================================================
// register offsets
`define SDC_STATUS_OFF 8'h00
`define SDC_MASK_OFF 8'h04
`define SDC_MODE_OFF 8'h08
`define SDC_CONFIG_OFF 8'h0C
`define SDC_FILTER_OFF 8'h10
`define SDC_CURRENT_OFF 8'h14
`define SDC_VOLTAGE_OFF 8'h18
`define SDC_TEMP_OFF 8'h1C
`define SDC_THRESH_OFF 8'h20
`define SDC_COUNT_OFF 8'h24
`define SDC_ACCUM_OFF 8'h28
// =====================================================
// status bits
`define SDC_ST_CURRDY 0
`define SDC_ST_VOLRDY 1
`define SDC_ST_TMPRDY 2
`define SDC_ST_OVR 3
`define SDC_ST_THR 4
`define SDC_ST_CAL 15
// =====================================================
// mode and config fields
`define SDC_MD_CUREN 0
`define SDC_MD_VTEN 1
`define SDC_MD_CAL 2
`define SDC_MD_LOWPWR 3
`define SDC_MD_CHOP 4
`define SDC_MD_CORE_OFF 5
`define SDC_MD_GSW_RES 6
`define SDC_CF_ACC 0
`define SDC_CF_CMP 1
`define SDC_CF_OVR 2
`define SDC_CF_CNT 3
`define SDC_CF_VSEL_LO 4
`define SDC_CF_GSW 7
// =====================================================
// input selection codes
`define SDC_SEL_VBAT 2'h0
`define SDC_SEL_EXT_TEMP 2'h1
`define SDC_SEL_INT_TEMP 2'h2
// =====================================================
// reset values and timing
`define SDC_FILTER_RST 16'h007F
`define SDC_SETTLE_CHOP 2'h2
`define SDC_SETTLE_NOCHOP 2'h3
`define SDC_BASE_DECIM 7'h40
`define SDC_OVR_PERIOD_US 125
`define SDC_CLK_MHZ 50
`define SDC_OVR_CYCLES (`SDC_OVR_PERIOD_US * `SDC_CLK_MHZ)
`endif

/* sdc_sinc3.v */
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// sinc3 decimator
module sdc_sinc3 #(
  parameter ACC_W = 40
) (
  input wire clk,
  input wire resetn,
  input wire enable,
  input wire modBit,
  input wire [23:0] decim,
  output reg [15:0] result,
  output reg clip,
  output reg done
);
  reg [ACC_W-1:0] i1Reg, i2Reg, i3Reg, d1Reg, d2Reg, d3Reg;
  reg [23:0] cntReg;
  wire [ACC_W-1:0] c1 = i3Reg - d1Reg;
  wire [ACC_W-1:0] c2 = c1 - d2Reg;
  wire [ACC_W-1:0] c3 = c2 - d3Reg;
  wire [ACC_W-1:0] dec = {{(ACC_W-24){1'b0}}, decim};
  wire [ACC_W-1:0] full = dec * dec * dec;
  wire [ACC_W-1:0] half = {1'b0, full[ACC_W-1:1]};
  wire signed [ACC_W:0] cen = $signed({1'b0, c3}) - $signed({1'b0, half});
  wire signed [ACC_W:0] scl = (cen <<< 16) / $signed({1'b0, full});
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      i1Reg <= {ACC_W{1'b0}};
      i2Reg <= {ACC_W{1'b0}};
      i3Reg <= {ACC_W{1'b0}};
      d1Reg <= {ACC_W{1'b0}};
      d2Reg <= {ACC_W{1'b0}};
      d3Reg <= {ACC_W{1'b0}};
      cntReg <= 24'h000000;
      result <= 16'h0000;
      clip <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (enable) begin
        i1Reg <= i1Reg + {{(ACC_W-1){1'b0}}, modBit};
        i2Reg <= i2Reg + i1Reg;
        i3Reg <= i3Reg + i2Reg;
        if (cntReg >= decim - 24'h000001) begin
          cntReg <= 24'h000000;
          d1Reg <= i3Reg;
          d2Reg <= c1;
          d3Reg <= c2;
          done <= 1'b1;
          if (scl > 32767) begin
            result <= 16'h7FFF;
            clip <= 1'b1;
          end else if (scl < -32768) begin
            result <= 16'h8000;
            clip <= 1'b1;
          end else begin
            result <= scl[15:0];
            clip <= 1'b0;
          end
        end else begin
          cntReg <= cntReg + 24'h000001;
        end
      end else begin
        cntReg <= 24'h000000;
      end
    end
  end
endmodule // sdc_sinc3
`default_nettype wire

/* sdc_converter_control_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sdc_regs.vh"
// =====================================================
// port checker
module sdc_converter_control_asserts #(
  parameter OVR_CYCLES = 10,
  parameter CAL_CYCLES = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regRdata,
  input wire logic [1:0] inputSelect,
  input wire logic attenBufferEn,
  input wire logic gndSwDirect,
  input wire logic gndSwResistor,
  input wire logic convIrq
);
  logic [7:0] cfgReg;
  logic [7:0] modeReg;
  logic [7:0] maskReg;
  // shadow copies of the low bytes written to config, mode and mask
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfgReg <= 8'h00;
      modeReg <= 8'h00;
      maskReg <= 8'h00;
    end else if (regWrite) begin
      if (regAddr == `SDC_CONFIG_OFF) cfgReg <= regWdata[7:0];
      if (regAddr == `SDC_MODE_OFF) modeReg <= regWdata[7:0];
      if (regAddr == `SDC_MASK_OFF) maskReg <= regWdata[7:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_gnd_float; !cfgReg[7] |-> !gndSwDirect && !gndSwResistor; endproperty
  a_gnd_float: assert property (p_gnd_float) else $error("ground switch not floating");
  property p_gnd_direct; cfgReg[7] && !modeReg[6] |-> gndSwDirect && !gndSwResistor; endproperty
  a_gnd_direct: assert property (p_gnd_direct) else $error("ground switch not direct");
  property p_gnd_res; cfgReg[7] && modeReg[6] |-> gndSwResistor && !gndSwDirect; endproperty
  a_gnd_res: assert property (p_gnd_res) else $error("ground switch not resistive");
  property p_sel; regWrite && regAddr == `SDC_CONFIG_OFF |=> inputSelect == $past(regWdata[5:4]); endproperty
  a_sel: assert property (p_sel) else $error("input select differs");
  property p_atten; attenBufferEn == (modeReg[1] && cfgReg[5:4] == `SDC_SEL_VBAT); endproperty
  a_atten: assert property (p_atten) else $error("attenuator buffer enable wrong");
  property p_mask_off; maskReg == 8'h00 ##1 maskReg == 8'h00 |-> !convIrq; endproperty
  a_mask_off: assert property (p_mask_off) else $error("interrupt with all sources masked");
  property p_idle; !$past(regRead) |-> regRdata == 32'h00000000; endproperty
  a_idle: assert property (p_idle) else $error("read data outside read cycle");
  property p_status_irq;
    regRead && regAddr == `SDC_STATUS_OFF ##1 (regRdata[7:0] & maskReg) != 8'h00 |-> convIrq || $past(convIrq);
  endproperty
  a_status_irq: assert property (p_status_irq) else $error("masked flag set without interrupt");
  property p_cal_clear;
    regWrite && regAddr == `SDC_MODE_OFF ##2 regRead && regAddr == `SDC_STATUS_OFF |=> !regRdata[`SDC_ST_CAL];
  endproperty
  a_cal_clear: assert property (p_cal_clear) else $error("calibration flag kept after mode write");
  property p_ovr_off;
    regWrite && regAddr == `SDC_CONFIG_OFF && !regWdata[`SDC_CF_OVR] ##2 regRead && regAddr == `SDC_STATUS_OFF
      |=> !regRdata[`SDC_ST_OVR];
  endproperty
  a_ovr_off: assert property (p_ovr_off) else $error("overrange flag kept after disable");
endmodule // sdc_converter_control_asserts
bind sdc_converter_control sdc_converter_control_asserts #(.OVR_CYCLES(OVR_CYCLES), .CAL_CYCLES(CAL_CYCLES))
  sdc_converter_control_asserts_i (.clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
  .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .inputSelect(inputSelect),
  .attenBufferEn(attenBufferEn), .gndSwDirect(gndSwDirect), .gndSwResistor(gndSwResistor), .convIrq(convIrq));
`default_nettype wire

/* sdc_modulator_model.sv */
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// first-order modulators at fixed input levels
module sdc_modulator_model (
  input wire logic clk,
  input wire logic ovrCmd,
  output logic curBit,
  output logic volBit,
  output logic ovrRaw
);
  logic [7:0] curAcc;
  logic [7:0] volAcc;
  initial begin
    curAcc = 8'h00;
    volAcc = 8'h00;
    curBit = 1'b0;
    volBit = 1'b1;
    ovrRaw = 1'b0;
  end
  always @(posedge clk) begin
    {curBit, curAcc} <= {1'b0, curAcc} + 9'h05B;
    {volBit, volAcc} <= {1'b0, volAcc} + 9'h0A7;
    ovrRaw <= ovrCmd;
  end
endmodule // sdc_modulator_model
`default_nettype wire

/* sdc_converter_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sdc_regs.vh"
// =====================================================
// testbench
module sdc_converter_control_tb;
  logic clk, resetn, regWrite, regRead, attenBufferEn, gndSwDirect, gndSwResistor, convIrq;
  logic curBit, volBit, ovrRaw, ovrCmd, rdSeen;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, v;
  logic [1:0] inputSelect;
  logic [31:0] expQ[$];
  logic [31:0] mskQ[$];
  int n_errors = 0;
  int n_compared = 0;
  int i, n;
  integer seed = 32'h87b98d8f;
  sdc_converter_control #(.OVR_CYCLES(10), .CAL_CYCLES(8)) sdc_converter_control_i (.clk(clk), .resetn(resetn),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .currentModBit(curBit), .voltageModBit(volBit), .currentOverrangeRaw(ovrRaw), .inputSelect(inputSelect),
    .attenBufferEn(attenBufferEn), .gndSwDirect(gndSwDirect), .gndSwResistor(gndSwResistor), .convIrq(convIrq));
  sdc_modulator_model sdc_modulator_model_i (.clk(clk), .ovrCmd(ovrCmd), .curBit(curBit), .volBit(volBit),
    .ovrRaw(ovrRaw));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic complete_run;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    expQ.push_back(e & m);
    mskQ.push_back(m);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
  endtask
  task automatic wait_irq;
    n = 0;
    while (convIrq !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    check({31'h0, convIrq}, 32'h00000001);
  endtask
  // =====================================================
  // read result monitor
  always @(posedge clk) rdSeen <= regRead;
  always @(negedge clk) begin
    if (rdSeen === 1'b1 && expQ.size() > 0) check(regRdata & mskQ.pop_front(), expQ.pop_front());
  end
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    complete_run;
  end
  // =====================================================
  // main sequence
  initial begin
    {regAddr, regWdata, regWrite, regRead, ovrCmd, rdSeen} = 'h0;
    resetn = 1'b0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    rd(`SDC_FILTER_OFF, 32'h0000007F, 32'h0000FFFF);
    rd(`SDC_THRESH_OFF, 32'h0000FFFF, 32'h0000FFFF);
    rd(`SDC_COUNT_OFF, 32'h00000001, 32'h0000FFFF);
    rd(`SDC_STATUS_OFF, 32'h00000000, 32'h0000FFFF);
    wr(`SDC_ACCUM_OFF, $random(seed));
    rd(`SDC_ACCUM_OFF, 32'h00000000, 32'hFFFFFFFF);
    rd(8'hFC, 32'h00000000, 32'hFFFFFFFF);
    for (i = 0; i < 4; i++) begin
      v = $random(seed);
      wr(`SDC_THRESH_OFF, v);
      rd(`SDC_THRESH_OFF, v, 32'h0000FFFF);
      wr(`SDC_CONFIG_OFF, {24'h0, i[1], 7'h0});
      wr(`SDC_MODE_OFF, {25'h0, i[0], 6'h0});
      @(negedge clk);
      check({30'h0, gndSwDirect, gndSwResistor}, {30'h0, i[1] & ~i[0], i[1] & i[0]});
    end
    for (i = 0; i < 3; i++) begin
      wr(`SDC_CONFIG_OFF, {26'h0, i[1:0], 4'h0});
      wr(`SDC_MODE_OFF, 32'h00000002);
      @(negedge clk);
      check({29'h0, attenBufferEn, inputSelect}, {29'h0, i == 0, i[1:0]});
    end
    v = $random(seed);
    wr(`SDC_MASK_OFF, v);
    rd(`SDC_MASK_OFF, v, 32'h000000FF);
    ovrCmd <= 1'b1;
    wr(`SDC_MODE_OFF, 32'h00000001);
    wr(`SDC_CONFIG_OFF, 32'h00000004);
    repeat (60) @(posedge clk);
    rd(`SDC_STATUS_OFF, 32'h00000008, 32'h00000008);
    wr(`SDC_CONFIG_OFF, 32'h00000001);
    rd(`SDC_STATUS_OFF, 32'h00000000, 32'h00000008);
    ovrCmd <= 1'b0;
    wr(`SDC_FILTER_OFF, 32'h00000000);
    wr(`SDC_MASK_OFF, 32'h00000007);
    wr(`SDC_MODE_OFF, 32'h00000003);
    wait_irq;
    check({31'h0, n >= 160 && n <= 200}, 32'h00000001);
    rd(`SDC_STATUS_OFF, 32'h00000001, 32'h00000001);
    rd(`SDC_ACCUM_OFF, 32'h80000000, 32'h80000000);
    repeat (64) @(posedge clk);
    rd(`SDC_VOLTAGE_OFF, 32'h00000000, 32'h00000000);
    @(negedge clk);
    v = regRdata;
    repeat (200) @(posedge clk);
    rd(`SDC_VOLTAGE_OFF, v, 32'h0000FFFF);
    wr(`SDC_MODE_OFF, 32'h00000000);
    rd(`SDC_STATUS_OFF, 32'h00000000, 32'h00008000);
    rd(`SDC_CURRENT_OFF, 32'h00000000, 32'h00000000);
    rd(`SDC_STATUS_OFF, 32'h00000000, 32'h00008007);
    @(negedge clk);
    check({31'h0, convIrq}, 32'h00000000);
    wr(`SDC_MODE_OFF, 32'h00000011);
    wait_irq;
    check({31'h0, n >= 110 && n <= 140}, 32'h00000001);
    wr(`SDC_MODE_OFF, 32'h00000000);
    rd(`SDC_CURRENT_OFF, 32'h00000000, 32'h00000000);
    wr(`SDC_MODE_OFF, 32'h00000002);
    wait_irq;
    check({31'h0, n >= 160 && n <= 200}, 32'h00000001);
    rd(`SDC_STATUS_OFF, 32'h00000002, 32'h00000007);
    wr(`SDC_MODE_OFF, 32'h00000000);
    rd(`SDC_VOLTAGE_OFF, 32'h00000000, 32'h00000000);
    rd(`SDC_STATUS_OFF, 32'h00000000, 32'h00000007);
    wr(`SDC_MASK_OFF, 32'h0000FFFF);
    wr(`SDC_MODE_OFF, 32'h00000004);
    repeat (40) @(posedge clk);
    rd(`SDC_STATUS_OFF, 32'h00008000, 32'h00008000);
    @(negedge clk);
    check({31'h0, convIrq}, 32'h00000000);
    repeat (4) @(posedge clk);
    complete_run;
  end
endmodule // sdc_converter_control_tb
`default_nettype wire
